// File: hdl/sdp_dual_port.sv
// Port control and array of a synchronous dual-port RAM with burst
// counters, counter masks, wrap flags and mailbox flags.
// Assumes both hosts drive their port from logic on clk_i; the global
// reset may arrive at any time.
//
// Contract
// - Strobe low loads address into burst counter
// - Count enable low increments counter each edge
// - Strobe or clear low blocks the increment
// - Clear zeroes only unmasked counter bits
// - Clear beats strobe and count enable
// - Mask select low targets mask register
// - Mask select high runs ordinary counter operations
// - Data driven on reads only while enable low
// - Top two addresses serve as mailboxes
// - Write to other port's mailbox lowers flag
// - Owner reading its mailbox raises flag
// - Wrap flag low when an increment leaves unmasked bits all ones
// - Read/write select low writes, high reads
// - Deselected byte lanes neither written nor read
// - Port selected when low select low, high high
// - Global reset asynchronous, resets both ports
// - Reset: counters zero, masks ones, flags high
// - Highest address right mailbox, next left
// - Mailbox flag changes need an active lane
`timescale 1ns/1ps

module sdp_dual_port #(
  parameter int ADDR_W = sdp_pkg::ADDR_W,
  parameter int DEPTH  = sdp_pkg::FIFO_DEPTH
) (
  // Clock and global reset
  input  wire logic                                          clk_i,
  input  wire logic                                          reset_n_i,
  // Address and counter control, index 0 left, 1 right
  input  wire logic [sdp_pkg::NUM_PORTS-1:0][ADDR_W-1:0]     addr_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 address_strobe_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 count_enable_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 counter_clear_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 mask_access_sel_n_i,
  // Access control
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 read_write_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0][sdp_pkg::LANES-1:0] byte_lane_sel_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 chip_sel_low_n_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 chip_sel_high_i,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 out_enable_n_i,
  // Data pins, split into in, out and enable
  input  wire logic [sdp_pkg::NUM_PORTS-1:0][sdp_pkg::DATA_W-1:0] dq_i,
  output logic      [sdp_pkg::NUM_PORTS-1:0][sdp_pkg::DATA_W-1:0] dq_o,
  output logic      [sdp_pkg::NUM_PORTS-1:0]                 dq_oe_o,
  // Read buffer handshake
  output logic      [sdp_pkg::NUM_PORTS-1:0]                 dq_valid_o,
  input  wire logic [sdp_pkg::NUM_PORTS-1:0]                 dq_ready_i,
  output logic      [sdp_pkg::NUM_PORTS-1:0]                 read_ready_o,
  // Flags and readback
  output logic      [sdp_pkg::NUM_PORTS-1:0]                 mailbox_flag_n_o,
  output logic      [sdp_pkg::NUM_PORTS-1:0]                 wrap_flag_n_o,
  output logic      [sdp_pkg::NUM_PORTS-1:0][ADDR_W-1:0]     addr_rb_o
);

  localparam int NP = sdp_pkg::NUM_PORTS;
  localparam int DW = sdp_pkg::DATA_W;
  localparam int LW = sdp_pkg::LANE_W;
  localparam int NL = sdp_pkg::LANES;
  localparam int WORDS = 1 << ADDR_W;

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Mailboxes need at least two words; very wide arrays are not served
  if (ADDR_W < 2 || ADDR_W > 20) begin : g_bad_addr
    $error("sdp_dual_port: ADDR_W must lie between 2 and 20");
  end

  // Mailbox addresses scale with the array depth
  localparam logic [ADDR_W-1:0] MBOX_R = ADDR_W'(WORDS - sdp_pkg::MBOX_RIGHT_FROM_TOP);
  localparam logic [ADDR_W-1:0] MBOX_L = ADDR_W'(WORDS - sdp_pkg::MBOX_LEFT_FROM_TOP);

  // ----------------------------------------------------------------
  // Input registers
  // ----------------------------------------------------------------
  logic [NP-1:0][ADDR_W-1:0] addr_q;     // Registered address
  logic [NP-1:0]             ads_n_q;    // Registered strobe
  logic [NP-1:0]             cen_n_q;    // Registered count enable
  logic [NP-1:0]             clr_n_q;    // Registered counter clear
  logic [NP-1:0]             msel_n_q;   // Registered mask select
  logic [NP-1:0]             rw_n_q;     // Registered read/write
  logic [NP-1:0][NL-1:0]     lane_n_q;   // Registered byte lanes
  logic [NP-1:0]             sel_q;      // Registered chip select
  logic [NP-1:0][DW-1:0]     wdat_q;     // Registered write data

  // Every control input except output enable and read buffer ready is captured on the edge before it acts
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_q   <= '0;
      ads_n_q  <= '1;
      cen_n_q  <= '1;
      clr_n_q  <= '1;
      msel_n_q <= '1;
      rw_n_q   <= '1;
      lane_n_q <= '1;
      sel_q    <= '0;
      wdat_q   <= '0;
    end else begin
      addr_q   <= addr_i;
      ads_n_q  <= address_strobe_n_i;
      cen_n_q  <= count_enable_n_i;
      clr_n_q  <= counter_clear_n_i;
      msel_n_q <= mask_access_sel_n_i;
      rw_n_q   <= read_write_n_i;
      lane_n_q <= byte_lane_sel_n_i;
      sel_q    <= ~chip_sel_low_n_i & chip_sel_high_i;
      wdat_q   <= dq_i;
    end
  end

  // ----------------------------------------------------------------
  // Counter, mask and flag state
  // ----------------------------------------------------------------
  logic [NP-1:0][ADDR_W-1:0] cnt_q, cnt_d;    // Burst counters
  logic [NP-1:0][ADDR_W-1:0] msk_q, msk_d;    // Mask, 1 = counting bit
  logic [NP-1:0]             wrap_q, wrap_d;  // Wrap flags, low active
  logic [NP-1:0]             mbox_q, mbox_d;  // Mailbox flags, low active
  logic [NP-1:0][ADDR_W-1:0] acc_addr;        // Address of this access
  logic [NP-1:0]             wr_go;           // Write taken
  logic [NP-1:0]             rd_go;           // Read taken
  logic [NP-1:0]             any_lane;        // At least one lane active
  logic [NP-1:0][DW-1:0]     rd_word;         // Lane-masked read word
  logic [NP-1:0]             fifo_rdy;        // Read buffer has room
  logic [ADDR_W-1:0]         inc_val;         // Scratch masked increment

  // Array, one memory per byte lane so lanes write on their own
  logic [LW-1:0] mem_q [NL][WORDS];

  // Next counter, mask and flag values for both ports
  always_comb begin
    inc_val = '0;
    cnt_d   = cnt_q;
    msk_d   = msk_q;
    wrap_d  = wrap_q;
    mbox_d  = mbox_q;
    for (int p = 0; p < NP; p++) begin
      any_lane[p] = ~&lane_n_q[p];
      // Strobe picks the pin address, otherwise the counter
      acc_addr[p] = ads_n_q[p] ? cnt_q[p] : addr_q[p];
      // Low writes, high reads; lanes gate writes
      wr_go[p]    = sel_q[p] & ~rw_n_q[p] & any_lane[p];
      // A full read buffer refuses the read rather than lose it
      rd_go[p]    = sel_q[p] & rw_n_q[p] & fifo_rdy[p];
      for (int l = 0; l < NL; l++) begin
        // Deselected lanes read back as zero
        rd_word[p][l*LW +: LW] = lane_n_q[p][l] ? LW'(0) : mem_q[l][acc_addr[p]];
      end
      if (!msel_n_q[p]) begin
        // Mask access: counter left alone
        if (!clr_n_q[p]) begin
          msk_d[p] = '1;
        end else if (!ads_n_q[p]) begin
          msk_d[p] = addr_q[p];
        end
      end else if (!clr_n_q[p]) begin
        // Clear wins over strobe and count enable
        cnt_d[p]  = cnt_q[p] & ~msk_q[p];
        wrap_d[p] = sdp_pkg::FLAG_IDLE;
      end else if (!ads_n_q[p]) begin
        cnt_d[p]  = addr_q[p];
        wrap_d[p] = sdp_pkg::FLAG_IDLE;
      end else if (!cen_n_q[p]) begin
        // Masked bits forced to one so the carry jumps over them
        inc_val   = ((cnt_q[p] | ~msk_q[p]) + ADDR_W'(1)) & msk_q[p];
        cnt_d[p]  = inc_val | (cnt_q[p] & ~msk_q[p]);
        wrap_d[p] = (inc_val == msk_q[p]) ? sdp_pkg::FLAG_SET
                                          : sdp_pkg::FLAG_IDLE;
      end
    end
    // Owner read clears its flag; the other port's write sets it and wins
    if (rd_go[sdp_pkg::PORT_RIGHT] && any_lane[sdp_pkg::PORT_RIGHT] &&
        acc_addr[sdp_pkg::PORT_RIGHT] == MBOX_R) begin
      mbox_d[sdp_pkg::PORT_RIGHT] = sdp_pkg::FLAG_IDLE;
    end
    if (wr_go[sdp_pkg::PORT_LEFT] && acc_addr[sdp_pkg::PORT_LEFT] == MBOX_R) begin
      mbox_d[sdp_pkg::PORT_RIGHT] = sdp_pkg::FLAG_SET;
    end
    if (rd_go[sdp_pkg::PORT_LEFT] && any_lane[sdp_pkg::PORT_LEFT] &&
        acc_addr[sdp_pkg::PORT_LEFT] == MBOX_L) begin
      mbox_d[sdp_pkg::PORT_LEFT] = sdp_pkg::FLAG_IDLE;
    end
    if (wr_go[sdp_pkg::PORT_RIGHT] && acc_addr[sdp_pkg::PORT_RIGHT] == MBOX_L) begin
      mbox_d[sdp_pkg::PORT_LEFT] = sdp_pkg::FLAG_SET;
    end
  end

  // State registers; global reset acts without the clock
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt_q  <= '0;
      msk_q  <= '1;
      wrap_q <= '1;
      mbox_q <= '1;
    end else begin
      cnt_q  <= cnt_d;
      msk_q  <= msk_d;
      wrap_q <= wrap_d;
      mbox_q <= mbox_d;
    end
  end

  // Array writes; right port written last, so a same-word collision
  // leaves a value the host must treat as undefined
  always_ff @(posedge clk_i) begin
    for (int p = 0; p < NP; p++) begin
      for (int l = 0; l < NL; l++) begin
        if (wr_go[p] && !lane_n_q[p][l]) begin
          mem_q[l][acc_addr[p]] <= wdat_q[p][l*LW +: LW];
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Read buffers and data pins
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NP; p++) begin : g_port
    sdp_fifo #(
      .WIDTH (DW),
      .DEPTH (DEPTH)
    ) u_rd_fifo (
      .clk_i       (clk_i),
      .reset_n_i   (reset_n_i),
      .in_valid_i  (rd_go[p]),
      .in_ready_o  (fifo_rdy[p]),
      .in_data_i   (rd_word[p]),
      .out_valid_o (dq_valid_o[p]),
      .out_ready_i (dq_ready_i[p]),
      .out_data_o  (dq_o[p])
    );
  end

  // Output enable gates the pins without waiting for a clock
  assign dq_oe_o          = dq_valid_o & ~out_enable_n_i;
  assign read_ready_o     = fifo_rdy;
  assign mailbox_flag_n_o = mbox_q;
  assign wrap_flag_n_o    = wrap_q;

  // Readback shows the mask while mask select is low
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      addr_rb_o[p] = msel_n_q[p] ? cnt_q[p] : msk_q[p];
    end
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);

  for (genvar p = 0; p < NP; p++) begin : g_chk
    clear_wins_a : assert property (msel_n_q[p] && !clr_n_q[p] |=>
      cnt_q[p] == ($past(cnt_q[p]) & ~$past(msk_q[p])))
      else $error("counter clear did not zero the unmasked bits");
    strobe_load_a : assert property (msel_n_q[p] && clr_n_q[p] && !ads_n_q[p] |=>
      cnt_q[p] == $past(addr_q[p]))
      else $error("strobe did not load the counter");
    full_incr_a : assert property (msel_n_q[p] && clr_n_q[p] && ads_n_q[p] && !cen_n_q[p]
      && &msk_q[p] |=> cnt_q[p] == $past(cnt_q[p]) + ADDR_W'(1))
      else $error("unmasked counter did not step by one");
    mask_route_a : assert property (!msel_n_q[p] |=> $stable(cnt_q[p]))
      else $error("counter moved during mask access");
    mask_hold_a : assert property (msel_n_q[p] |=> $stable(msk_q[p]))
      else $error("mask changed outside mask access");
    wrap_value_a : assert property ($fell(wrap_q[p]) |-> (cnt_q[p] & msk_q[p]) == msk_q[p])
      else $error("wrap flag fell without all ones in unmasked bits");
    pin_drive_a : assert property (dq_oe_o[p] |-> !out_enable_n_i[p] && dq_valid_o[p])
      else $error("data pins driven without output enable");
    lane_read_a : assert property (rd_go[p] && lane_n_q[p][0] |-> rd_word[p][LW-1:0] == '0)
      else $error("deselected lane returned data");
  end

  mbox_set_a : assert property (wr_go[sdp_pkg::PORT_LEFT] &&
    acc_addr[sdp_pkg::PORT_LEFT] == MBOX_R |=> !mailbox_flag_n_o[sdp_pkg::PORT_RIGHT])
    else $error("write to right mailbox did not lower its flag");
  mbox_clear_a : assert property (rd_go[sdp_pkg::PORT_LEFT] &&
    any_lane[sdp_pkg::PORT_LEFT] && acc_addr[sdp_pkg::PORT_LEFT] == MBOX_L &&
    !(wr_go[sdp_pkg::PORT_RIGHT] && acc_addr[sdp_pkg::PORT_RIGHT] == MBOX_L)
    |=> mailbox_flag_n_o[sdp_pkg::PORT_LEFT])
    else $error("owner read did not raise left mailbox flag");

endmodule : sdp_dual_port

// File: hdl/sdp_pkg.sv
// Package for the synchronous dual-port RAM port control.
// Assumes both ports run on one clock and one active-low global reset.
package sdp_pkg;

  // ----------------------------------------------------------------
  // Widths and geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS  = 2;   // Left and right port
  localparam int PORT_LEFT  = 0;   // Index of the left port
  localparam int PORT_RIGHT = 1;   // Index of the right port
  localparam int DATA_W     = 18;  // Data word width
  localparam int LANE_W     = 9;   // One byte lane, parity included
  localparam int LANES      = 2;   // Byte lanes per word
  localparam int ADDR_W     = 15;  // Default address width

  // ----------------------------------------------------------------
  // Mailbox placement, counted down from the top address
  // ----------------------------------------------------------------
  localparam int MBOX_RIGHT_FROM_TOP = 1;  // Highest address
  localparam int MBOX_LEFT_FROM_TOP  = 2;  // Next lower address

  // ----------------------------------------------------------------
  // Read buffer and reset values
  // ----------------------------------------------------------------
  localparam int   FIFO_DEPTH = 16;    // Read words buffered per port
  localparam logic FLAG_IDLE  = 1'b1;  // Flags rest high
  localparam logic FLAG_SET   = 1'b0;  // Flags assert low

endpackage : sdp_pkg

// File: hdl/sdp_fifo.sv
// Synchronous FIFO that buffers read data on its way to the data pins.
// Assumes writer and reader share one clock and the global reset.
`timescale 1ns/1ps

module sdp_fifo #(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input  wire logic             clk_i,
  input  wire logic             reset_n_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  // Pointers wrap naturally, so the depth must be a power of two
  if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("sdp_fifo: DEPTH must be a power of two of at least 2");
  end

  localparam int PW = $clog2(DEPTH);

  // ----------------------------------------------------------------
  // Storage and pointers
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] mem_q [DEPTH];  // Buffered words
  logic [PW-1:0]    wr_q, wr_d;     // Next slot to fill
  logic [PW-1:0]    rd_q, rd_d;     // Oldest slot
  logic [PW:0]      cnt_q, cnt_d;   // Words held
  logic             push, pop;      // Accepted transfers

  assign in_ready_o  = (cnt_q != PW'(0) + (PW+1)'(DEPTH)) ? 1'b1 : 1'b0;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o  = mem_q[rd_q];
  assign push        = in_valid_i & in_ready_o;
  assign pop         = out_valid_o & out_ready_i;

  // Next pointer and level values
  always_comb begin
    wr_d  = push ? wr_q + PW'(1) : wr_q;
    rd_d  = pop ? rd_q + PW'(1) : rd_q;
    cnt_d = cnt_q + (PW+1)'(push) - (PW+1)'(pop);
  end

  // Pointer registers
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      wr_q  <= wr_d;
      rd_q  <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; only filled slots are ever read
  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end

endmodule : sdp_fifo

// File: tb/sdp_host.sv
// Host model for one port: takes words from the read buffer of the device.
// Assumes valid and data come from the device's read buffer on the same clock.
`timescale 1ns/1ps

module sdp_host (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       reset_n_i,
  // Stall request from the bench
  input  wire logic                       stall_i,
  // Read buffer handshake
  input  wire logic                       valid_i,
  input  wire logic [sdp_pkg::DATA_W-1:0] data_i,
  output logic                            ready_o,
  // Last word taken and its one-cycle strobe
  output logic      [sdp_pkg::DATA_W-1:0] word_o,
  output logic                            got_o
);
  // ----------------------------------------------------------------
  // Handshake
  // ----------------------------------------------------------------
  // Ready is a plain level; a stalling host lets the buffer fill up
  assign ready_o = ~stall_i;

  // Take the head only on an edge with valid and ready both high
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_o <= 18'h00000;
      got_o  <= 1'b0;
    end else begin
      got_o <= valid_i & ready_o;
      if (valid_i & ready_o) begin
        word_o <= data_i;
      end
    end
  end
endmodule // sdp_host

// File: tb/dual_port_ram_port_control_test.sv
// Self-checking bench for the dual-port RAM port control.
// Assumes a 50 MHz clock, both ports driven from it, random seed fixed.
`timescale 1ns/1ps

module dual_port_ram_port_control_test;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int AW = 8;                 // Small array keeps mailboxes at FF/FE
  localparam int DW = sdp_pkg::DATA_W;   // Data word width
  logic                clk_i     = 1'b0; // Bench clock
  logic                reset_n_i = 1'b0; // Global reset, held at start
  logic [1:0][AW-1:0]  addr, rb;         // Address pins and readback
  logic [1:0]          ads_n, cen_n, clr_n, msk_n, rw, csl_n, csh, oe_n;
  logic [1:0]          rdy, stall, dqv, dqoe, rrdy, mbf, wrf, got;
  logic [1:0][1:0]     be_n;             // Lane selects
  logic [1:0][DW-1:0]  tb_dq, dq_in, dq_out, word;
  int                  errors    = 0;    // Mismatches
  int                  cmp_count = 0;    // Comparisons
  int                  cycles    = 0;    // Timeout counter

  // ----------------------------------------------------------------
  // Design, hosts and data wire
  // ----------------------------------------------------------------
  sdp_dual_port #(.ADDR_W(AW)) dut_u (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr), .address_strobe_n_i(ads_n),
    .count_enable_n_i(cen_n), .counter_clear_n_i(clr_n), .mask_access_sel_n_i(msk_n),
    .read_write_n_i(rw), .byte_lane_sel_n_i(be_n), .chip_sel_low_n_i(csl_n),
    .chip_sel_high_i(csh), .out_enable_n_i(oe_n), .dq_i(dq_in), .dq_o(dq_out),
    .dq_oe_o(dqoe), .dq_valid_o(dqv), .dq_ready_i(rdy), .read_ready_o(rrdy),
    .mailbox_flag_n_o(mbf), .wrap_flag_n_o(wrf), .addr_rb_o(rb));

  for (genvar p = 0; p < 2; p++) begin : g_host
    // Pin level: device drives when enabled, else the bench's pattern
    assign dq_in[p] = dqoe[p] ? dq_out[p] : tb_dq[p];
    sdp_host host_u (.clk_i(clk_i), .reset_n_i(reset_n_i), .stall_i(stall[p]),
      .valid_i(dqv[p]), .data_i(dq_out[p]), .ready_o(rdy[p]), .word_o(word[p]), .got_o(got[p]));
  end

  // ----------------------------------------------------------------
  // Clock and timeout
  // ----------------------------------------------------------------
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Tasks and functions
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Lane mask of the selected lanes, lane0 = bits 8:0
  function automatic logic [DW-1:0] lm(input logic [1:0] l);
    return {{9{~l[1]}}, {9{~l[0]}}};
  endfunction

  // c = {strobe, count, clear, mask select}, all active low; cs = {low sel, high sel}
  task automatic put(input int p, input logic [AW-1:0] a, input logic [3:0] c, input logic r,
                     input logic [1:0] cs, input logic [1:0] l, input logic [DW-1:0] d);
    addr[p] = a;
    {ads_n[p], cen_n[p], clr_n[p], msk_n[p]} = c;
    rw[p] = r;
    {csl_n[p], csh[p]} = cs;
    be_n[p] = l;
    tb_dq[p] = d;
  endtask

  // One request cycle, then idle; returns once the action has landed
  task automatic op(input int p, input logic [AW-1:0] a, input logic [3:0] c, input logic r,
                    input logic [1:0] cs, input logic [1:0] l, input logic [DW-1:0] d);
    put(p, a, c, r, cs, l, d);
    @(posedge clk_i);
    #1;
    // Released pins show the inverse, not a stale value
    put(p, addr[p], 4'hF, 1'b1, 2'b10, 2'b11, ~d);
    @(posedge clk_i);
    #1;
  endtask

  // Read through the strobe and wait a bounded time for the host to take it
  task automatic rd(input int p, input logic [AW-1:0] a, input logic [1:0] l, input logic [DW-1:0] exp);
    int n;
    op(p, a, 4'h7, 1'b1, 2'b01, l, '0);
    for (n = 0; n < 6 && got[p] !== 1'b1; n++) begin
      @(posedge clk_i);
      #1;
    end
    chk(got[p], 1'b1);
    chk(word[p], exp);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int i;
    int n;
    logic [AW-1:0] a;
    logic [DW-1:0] d1, d2;
    logic [1:0]    wl, rl;
    void'($urandom(55220));
    addr = '0; ads_n = '1; cen_n = '1; clr_n = '1; msk_n = '1; rw = '1;
    csl_n = '1; csh = '0; oe_n = '1; stall = '0; be_n = '1; tb_dq = '0;
    repeat (2) @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    chk(rb, 16'h0000);
    chk({mbf, wrf}, 4'hF);
    chk({dqv, rrdy}, 4'h3);
    // Random full then partial writes on one port, read on the other
    for (i = 0; i < 8; i++) begin
      a  = AW'($urandom_range(200));
      d1 = DW'($urandom);
      d2 = DW'($urandom);
      wl = 2'($urandom);
      rl = 2'($urandom_range(2));
      op(i % 2, a, 4'h7, 1'b0, 2'b01, 2'b00, d1);
      op(i % 2, a, 4'h7, 1'b0, 2'b01, wl, d2);
      rd(1 - i % 2, a, rl, ((d2 & lm(wl)) | (d1 & ~lm(wl))) & lm(rl));
    end
    // A half-selected port must not write
    op(0, 8'h10, 4'h7, 1'b0, 2'b01, 2'b00, 18'h2AAAA);
    for (i = 0; i < 2; i++) begin
      op(0, 8'h10, 4'h7, 1'b0, {i[0], i[0]}, 2'b00, 18'h15555);
    end
    rd(1, 8'h10, 2'b00, 18'h2AAAA);
    // Counter load, mask load and mask readback
    op(0, 8'h30, 4'h7, 1'b1, 2'b10, 2'b11, '0);
    chk(rb[0], 8'h30);
    op(0, 8'h0F, 4'h6, 1'b1, 2'b10, 2'b11, '0);
    msk_n[0] = 1'b0;
    @(posedge clk_i);
    #1;
    chk(rb[0], 8'h0F);
    msk_n[0] = 1'b1;
    @(posedge clk_i);
    #1;
    chk(rb[0], 8'h30);
    // Fifteen increments reach the top of the unmasked range
    cen_n[0] = 1'b0;
    repeat (15) @(posedge clk_i);
    #1 cen_n[0] = 1'b1;
    @(posedge clk_i);
    #1;
    chk(rb[0], 8'h3F);
    chk(wrf[0], 1'b0);
    op(0, 8'h00, 4'hB, 1'b1, 2'b10, 2'b11, '0);
    chk({wrf[0], rb[0]}, 9'h130);
    op(0, 8'h55, 4'h3, 1'b1, 2'b10, 2'b11, '0);
    chk(rb[0], 8'h55);
    op(0, 8'h99, 4'h1, 1'b1, 2'b10, 2'b11, '0);
    chk(rb[0], 8'h50);
    // Mask reset first, so the clear that follows zeroes every bit
    op(0, 8'h00, 4'hC, 1'b1, 2'b10, 2'b11, '0);
    op(0, 8'h00, 4'hD, 1'b1, 2'b10, 2'b11, '0);
    chk(rb[0], 8'h00);
    op(0, 8'hFE, 4'h7, 1'b1, 2'b10, 2'b11, '0);
    op(0, 8'h00, 4'hB, 1'b1, 2'b10, 2'b11, '0);
    chk({wrf[0], rb[0]}, 9'h0FF);
    // Mailboxes: FF belongs to the right port, FE to the left
    // Both lanes written so the later full-word read has no unwritten lane
    op(0, 8'hFF, 4'h7, 1'b0, 2'b01, 2'b00, 18'h00123);
    chk(mbf, 2'b01);
    op(0, 8'hFE, 4'h7, 1'b0, 2'b01, 2'b00, 18'h00456);
    chk(mbf, 2'b01);
    rd(0, 8'hFF, 2'b00, 18'h00123);
    chk(mbf, 2'b01);
    op(1, 8'hFF, 4'h7, 1'b1, 2'b01, 2'b11, '0);
    repeat (3) @(posedge clk_i);
    #1;
    chk(mbf, 2'b01);
    rd(1, 8'hFF, 2'b10, 18'h00123);
    chk(mbf, 2'b11);
    op(1, 8'hFE, 4'h7, 1'b0, 2'b01, 2'b11, 18'h00003);
    chk(mbf, 2'b11);
    op(1, 8'hFE, 4'h7, 1'b0, 2'b01, 2'b01, 18'h3FE00);
    chk(mbf, 2'b10);
    rd(0, 8'hFE, 2'b00, 18'h3FE56);
    chk(mbf, 2'b11);
    // Fill the read buffer with the host stalled, then drain it
    stall[1] = 1'b1;
    for (i = 0; i < 17; i++) begin
      op(1, 8'h10, 4'h7, 1'b1, 2'b01, 2'b00, '0);
    end
    chk(rrdy[1], 1'b0);
    oe_n[1] = 1'b0;
    #1 chk(dqoe[1], 1'b1);
    oe_n[1] = 1'b1;
    #1 chk(dqoe[1], 1'b0);
    stall[1] = 1'b0;
    n = 0;
    for (i = 0; i < 40; i++) begin
      @(posedge clk_i);
      #1;
      if (got[1] === 1'b1) begin
        n++;
        chk(word[1], 18'h2AAAA);
      end
    end
    chk(n, 16);
    chk({dqv[1], rrdy[1]}, 2'b01);
    // Reset in mid-run with the left flag low and the right counter at FE
    op(1, 8'hFE, 4'h7, 1'b0, 2'b01, 2'b00, 18'h00001);
    chk(mbf, 2'b10);
    reset_n_i = 1'b0;
    #1 chk(rb, 16'h0000);
    chk({mbf, wrf}, 4'hF);
    @(posedge clk_i);
    #1 reset_n_i = 1'b1;
    @(posedge clk_i);
    #1;
    // The first load after reset must land normally
    op(0, 8'h21, 4'h7, 1'b1, 2'b10, 2'b11, '0);
    chk(rb, 16'h0021);
    close_out();
  end
endmodule // dual_port_ram_port_control_test
